// >>> include/sched_cfg.svh
/*
 * Register offsets, field positions, reset values, encodings and timing
 * counts of the wake scheduler and interrupt-mode block.
 * Assumes a 100 MHz core clock.
 */
`ifndef SCHED_CFG_SVH
`define SCHED_CFG_SVH

`define REG_IRQ_MODE 8'h06
`define REG_UNLOCK_KEY 8'h07
`define REG_WAKE_CODE 8'h08
`define REG_ALS_CODE 8'h09
`define REG_RESET 8'h00
`define REG_UNMAPPED 8'h00

`define CMD_MODE_HI 3
`define CMD_MODE_LO 2
`define P3_MODE_HI 1
`define P3_MODE_LO 0

`define CMD_MODE_ANY 2'b00
`define CMD_MODE_ERR 2'b01
`define P3_MODE_DONE 2'b00
`define P3_MODE_CROSS 2'b01
`define P3_MODE_ABOVE 2'b11

`define UNLOCK_VALUE 8'h17
`define I2C_DEV_ADDR 7'h5a

`define ALS_TUNED_CODE 8'h32
`define ALS_TUNED_VALUE 16'h000a

`define CLK_PERIOD_NS 10
`define WAKE_TICK_NS 31250
`define WAKE_TICK_CYCLES ((`WAKE_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> include/sched_pkg.sv
/*
 * Types shared by the wake scheduler files.
 * Assumes nothing beyond the configuration header.
 */
package sched_pkg;

	typedef struct packed {
		logic done;
		logic [15:0] value;
	} prox_meas_type;

	typedef enum logic [3:0] {
		I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_PTR, I2C_PACK,
		I2C_WDAT, I2C_DACK, I2C_RD, I2C_RACK, I2C_RLD
	} i2c_state_type;

endpackage : sched_pkg

// >>> src/rate_code_expand.sv
/*
 * Expands an 8-bit compressed rate code into a 16-bit integer.
 * Purely combinational; the caller registers the code.
 */
`timescale 1ns/1ps
`include "sched_cfg.svh"

module rate_code_expand #(
	parameter bit ALS_TABLE = 1'b0
) (
	input wire logic [7:0] code_i,
	output logic [15:0] value_o
);
	logic [19:0] wide;

	always_comb begin
		// Upper nibble is exponent, lower nibble a mantissa with hidden one
		wide = {15'h0000, 1'b1, code_i[3:0]} << code_i[7:4];
		value_o = wide[19:4];
		if (code_i == 8'h00) begin
			value_o = 16'h0000;
		end else if (ALS_TABLE && code_i == `ALS_TUNED_CODE) begin
			// Code 0x32 alone is tuned to the round decimal multiplier ten
			value_o = `ALS_TUNED_VALUE;
		end
	end

endmodule : rate_code_expand

// >>> src/prox3_irq_eval.sv
/*
 * Interrupt flag of the third proximity channel with its three modes.
 * Assumes measurement results and threshold come from the core clock.
 */
`timescale 1ns/1ps
`include "sched_cfg.svh"

module prox3_irq_eval
	import sched_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [1:0] mode_i,
	input wire prox_meas_type meas_i,
	input wire logic [15:0] threshold_i,
	input wire logic clr_i,
	output logic flag_o
);
	logic above_r;
	logic above_nxt;
	logic flag_r;
	logic flag_nxt;
	logic hit;

	always_comb begin
		hit = 1'b0;
		above_nxt = above_r;
		if (meas_i.done) begin
			above_nxt = meas_i.value > threshold_i;
			case (mode_i)
				`P3_MODE_DONE: hit = 1'b1;
				`P3_MODE_CROSS: hit = above_nxt != above_r;
				`P3_MODE_ABOVE: hit = above_nxt;
				default: hit = 1'b0;
			endcase
		end
		// A new event outweighs a clear in the same cycle
		flag_nxt = hit | (flag_r & ~clr_i);
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			above_r <= 1'b0;
			flag_r <= 1'b0;
		end else begin
			above_r <= above_nxt;
			flag_r <= flag_nxt;
		end
	end

	assign flag_o = flag_r;

	a_p3_done_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		meas_i.done && mode_i == 2'b00 |=> flag_o)
		else $error("third channel flag missed a completed measurement");
	a_p3_cross_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		meas_i.done && mode_i == 2'b01 &&
		((meas_i.value > threshold_i) != above_r) |=> flag_o)
		else $error("third channel flag missed a threshold crossing");
	a_p3_above_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		meas_i.done && mode_i == 2'b11 &&
		meas_i.value > threshold_i |=> flag_o)
		else $error("third channel flag missed a value above threshold");
	a_p3_no_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!meas_i.done && clr_i |=> !flag_o)
		else $error("third channel flag set without a measurement");

endmodule : prox3_irq_eval

// >>> src/sensor_wake_scheduler.sv
/*
 * I2C-reached configuration registers, command and third proximity
 * interrupt logic, and the autonomous wake and ambient light scheduler.
 * Assumes SCL and SDA arrive asynchronously and are synchronised here;
 * sequencer and measurement strobes come from the same clock.
 */
// Functional notes
// - Command interrupt mode sets the flag whatever command interrupt enable is; the enable only gates the pin.
// - Mode 00: every reply register write sets the command flag.
// - Mode 01: only replies with top bit set set the flag; 1x reserved.
// - Third channel mode 00: each completed measurement sets its flag.
// - Third channel mode 01: crossing the threshold either way sets flag.
// - Third channel mode 11: measurement above threshold sets the flag.
// - Wake interval is expanded wake code times 31.25 us.
// - Wake code zero stops the oscillator and all autonomous wakes.
// - Wake code 0x84 expands to 0x140, ten milliseconds.
// - Wake code 0x94 expands to 0x280, twenty milliseconds.
// - Wake code 0xB9 expands to 0x0C80, one hundred milliseconds.
// - Wake code 0xDF expands to 0x3E00, 496 milliseconds.
// - Wake code 0xFF expands to 0xF800, about two seconds.
// - Ambient code expands to multiplier; one measurement per that many wakes.
// - Ambient code zero stops ambient measurements; wakes continue.
// - Ambient code 0x08 gives multiplier one: every wake.
// - Ambient code 0x32 gives multiplier ten.
// - Ambient code 0x69 gives multiplier one hundred.
// - Command enable set: command flag drives the interrupt line.
// - Third channel enable set: its flag drives the interrupt line.
// - Output enable set: line pulled low while any enabled flag set.
`timescale 1ns/1ps
`include "sched_cfg.svh"

module sensor_wake_scheduler
	import sched_pkg::*;
#(
	parameter int TICK_CYCLES = `WAKE_TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic reply_wr_i,
	input wire logic [7:0] reply_data_i,
	input wire logic cmd_irq_enable_i,
	input wire logic prox3_irq_enable_i,
	input wire logic int_out_enable_i,
	input wire logic cmd_flag_clr_i,
	input wire logic prox3_flag_clr_i,
	input wire prox_meas_type prox3_meas_i,
	input wire logic [15:0] prox3_threshold_i,
	output logic int_o,
	output logic int_oe_o,
	output logic cmd_irq_flag_o,
	output logic prox3_irq_flag_o,
	output logic unlocked_o,
	output logic osc_run_o,
	output logic wake_o,
	output logic als_meas_o
);
	// Pin synchronisers: stage 1 feeds stage 2 only
	logic scl_s1_r;
	logic scl_s2_r;
	logic scl_s3_r;
	logic sda_s1_r;
	logic sda_s2_r;
	logic sda_s3_r;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_s3_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_s3_r <= 1'b1;
		end else begin
			scl_s1_r <= scl_i;
			scl_s2_r <= scl_s1_r;
			scl_s3_r <= scl_s2_r;
			sda_s1_r <= sda_i;
			sda_s2_r <= sda_s1_r;
			sda_s3_r <= sda_s2_r;
		end
	end

	assign scl_rise = scl_s2_r & ~scl_s3_r;
	assign scl_fall = ~scl_s2_r & scl_s3_r;
	assign i2c_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
	assign i2c_stop = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

	// Register file
	logic [3:0] mode_r;
	logic [3:0] mode_nxt;
	logic [7:0] key_r;
	logic [7:0] key_nxt;
	logic [7:0] wake_code_r;
	logic [7:0] wake_code_nxt;
	logic [7:0] als_code_r;
	logic [7:0] als_code_nxt;
	logic [7:0] rdata;

	// I2C slave state
	i2c_state_type st_r;
	i2c_state_type st_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [7:0] ptr_r;
	logic [7:0] ptr_nxt;
	logic rw_r;
	logic rw_nxt;
	logic oe_r;
	logic oe_nxt;
	logic wr_r;
	logic wr_nxt;

	always_comb begin
		if (ptr_r == `REG_IRQ_MODE) begin
			rdata = {4'h0, mode_r};
		end else if (ptr_r == `REG_UNLOCK_KEY) begin
			rdata = key_r;
		end else if (ptr_r == `REG_WAKE_CODE) begin
			rdata = wake_code_r;
		end else if (ptr_r == `REG_ALS_CODE) begin
			rdata = als_code_r;
		end else begin
			rdata = `REG_UNMAPPED;
		end
	end

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		ptr_nxt = ptr_r;
		rw_nxt = rw_r;
		oe_nxt = oe_r;
		wr_nxt = 1'b0;
		if (i2c_start) begin
			st_nxt = I2C_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt = 1'b0;
		end else if (i2c_stop) begin
			st_nxt = I2C_IDLE;
			oe_nxt = 1'b0;
		end else if (scl_rise) begin
			case (st_r)
				I2C_ADDR, I2C_PTR, I2C_WDAT: begin
					sh_nxt = {sh_r[6:0], sda_s2_r};
					cnt_nxt = cnt_r + 4'h1;
				end
				I2C_RD: cnt_nxt = cnt_r + 4'h1;
				I2C_RACK: begin
					// A master NACK ends the read; wait for stop
					if (sda_s2_r) begin
						st_nxt = I2C_IDLE;
					end else begin
						ptr_nxt = ptr_r + 8'h01;
						st_nxt = I2C_RLD;
					end
				end
				default: st_nxt = st_r;
			endcase
		end else if (scl_fall) begin
			case (st_r)
				I2C_ADDR: begin
					if (cnt_r == 4'h8) begin
						if (sh_r[7:1] == `I2C_DEV_ADDR) begin
							oe_nxt = 1'b1;
							rw_nxt = sh_r[0];
							st_nxt = I2C_AACK;
						end else begin
							st_nxt = I2C_IDLE;
						end
					end
				end
				I2C_AACK, I2C_RLD: begin
					cnt_nxt = 4'h0;
					if (rw_r) begin
						sh_nxt = rdata;
						oe_nxt = ~rdata[7];
						st_nxt = I2C_RD;
					end else begin
						oe_nxt = 1'b0;
						st_nxt = I2C_PTR;
					end
				end
				I2C_PTR: begin
					if (cnt_r == 4'h8) begin
						ptr_nxt = sh_r;
						oe_nxt = 1'b1;
						st_nxt = I2C_PACK;
					end
				end
				I2C_PACK, I2C_DACK: begin
					if (st_r == I2C_DACK) begin
						ptr_nxt = ptr_r + 8'h01;
					end
					oe_nxt = 1'b0;
					cnt_nxt = 4'h0;
					st_nxt = I2C_WDAT;
				end
				I2C_WDAT: begin
					if (cnt_r == 4'h8) begin
						wr_nxt = 1'b1;
						oe_nxt = 1'b1;
						st_nxt = I2C_DACK;
					end
				end
				I2C_RD: begin
					if (cnt_r == 4'h8) begin
						oe_nxt = 1'b0;
						st_nxt = I2C_RACK;
					end else begin
						sh_nxt = {sh_r[6:0], 1'b0};
						oe_nxt = ~sh_r[6];
					end
				end
				default: st_nxt = st_r;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st_r <= I2C_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			oe_r <= 1'b0;
			wr_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			ptr_r <= ptr_nxt;
			rw_r <= rw_nxt;
			oe_r <= oe_nxt;
			wr_r <= wr_nxt;
		end
	end

	// Write lands one cycle after the eighth data bit's falling SCL
	always_comb begin
		mode_nxt = mode_r;
		key_nxt = key_r;
		wake_code_nxt = wake_code_r;
		als_code_nxt = als_code_r;
		if (wr_r) begin
			if (ptr_r == `REG_IRQ_MODE) begin
				mode_nxt = sh_r[3:0];
			end else if (ptr_r == `REG_UNLOCK_KEY) begin
				key_nxt = sh_r;
			end else if (ptr_r == `REG_WAKE_CODE) begin
				// Codes 0x01..0x17 are the host's to avoid
				wake_code_nxt = sh_r;
			end else if (ptr_r == `REG_ALS_CODE) begin
				als_code_nxt = sh_r;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			mode_r <= 4'(`REG_RESET);
			key_r <= `REG_RESET;
			wake_code_r <= `REG_RESET;
			als_code_r <= `REG_RESET;
		end else begin
			mode_r <= mode_nxt;
			key_r <= key_nxt;
			wake_code_r <= wake_code_nxt;
			als_code_r <= als_code_nxt;
		end
	end

	// Interrupt flags and pin
	logic [1:0] cmd_mode;
	logic cmd_hit;
	logic cmd_flag_r;
	logic cmd_flag_nxt;
	logic p3_flag;
	logic int_oe_r;
	logic int_oe_nxt;
	logic unlocked_r;
	logic unlocked_nxt;

	assign cmd_mode = mode_r[`CMD_MODE_HI:`CMD_MODE_LO];

	always_comb begin
		cmd_hit = 1'b0;
		if (reply_wr_i) begin
			case (cmd_mode)
				`CMD_MODE_ANY: cmd_hit = 1'b1;
				`CMD_MODE_ERR: cmd_hit = reply_data_i[7];
				default: cmd_hit = 1'b0;
			endcase
		end
		cmd_flag_nxt = cmd_hit | (cmd_flag_r & ~cmd_flag_clr_i);
		int_oe_nxt = int_out_enable_i &
			((cmd_flag_r & cmd_irq_enable_i) |
			(p3_flag & prox3_irq_enable_i));
		// Only reported; the host is expected to unlock first
		unlocked_nxt = key_r == `UNLOCK_VALUE;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cmd_flag_r <= 1'b0;
			int_oe_r <= 1'b0;
			unlocked_r <= 1'b0;
		end else begin
			cmd_flag_r <= cmd_flag_nxt;
			int_oe_r <= int_oe_nxt;
			unlocked_r <= unlocked_nxt;
		end
	end

	prox3_irq_eval u_prox3 (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.mode_i(mode_r[`P3_MODE_HI:`P3_MODE_LO]),
		.meas_i(prox3_meas_i),
		.threshold_i(prox3_threshold_i),
		.clr_i(prox3_flag_clr_i),
		.flag_o(p3_flag)
	);

	// Wake and ambient light scheduler
	logic [15:0] wake_period;
	logic [15:0] als_mult;
	logic [15:0] tick_r;
	logic [15:0] tick_nxt;
	logic [15:0] per_r;
	logic [15:0] per_nxt;
	logic [15:0] als_cnt_r;
	logic [15:0] als_cnt_nxt;
	logic wake_r;
	logic wake_nxt;
	logic als_r;
	logic als_nxt;
	logic osc_r;
	logic osc_nxt;

	rate_code_expand #(.ALS_TABLE(1'b0)) u_wake_dec (
		.code_i(wake_code_r),
		.value_o(wake_period)
	);

	rate_code_expand #(.ALS_TABLE(1'b1)) u_als_dec (
		.code_i(als_code_r),
		.value_o(als_mult)
	);

	always_comb begin
		tick_nxt = tick_r;
		per_nxt = per_r;
		als_cnt_nxt = als_cnt_r;
		wake_nxt = 1'b0;
		als_nxt = 1'b0;
		osc_nxt = wake_code_r != 8'h00;
		if (wake_code_r == 8'h00) begin
			// Oscillator off: counters held cleared
			tick_nxt = 16'h0000;
			per_nxt = 16'h0000;
			als_cnt_nxt = 16'h0000;
		end else if (tick_r >= 16'(TICK_CYCLES - 1)) begin
			tick_nxt = 16'h0000;
			if (per_r >= wake_period - 16'h0001) begin
				per_nxt = 16'h0000;
				wake_nxt = 1'b1;
				if (als_mult == 16'h0000) begin
					als_cnt_nxt = 16'h0000;
				end else if (als_cnt_r <= 16'h0001) begin
					als_cnt_nxt = als_mult;
					als_nxt = 1'b1;
				end else begin
					als_cnt_nxt = als_cnt_r - 16'h0001;
				end
			end else begin
				per_nxt = per_r + 16'h0001;
			end
		end else begin
			tick_nxt = tick_r + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tick_r <= 16'h0000;
			per_r <= 16'h0000;
			als_cnt_r <= 16'h0000;
			wake_r <= 1'b0;
			als_r <= 1'b0;
			osc_r <= 1'b0;
		end else begin
			tick_r <= tick_nxt;
			per_r <= per_nxt;
			als_cnt_r <= als_cnt_nxt;
			wake_r <= wake_nxt;
			als_r <= als_nxt;
			osc_r <= osc_nxt;
		end
	end

	// Open drain pins: only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_r;
	assign int_o = 1'b0;
	assign int_oe_o = int_oe_r;
	assign cmd_irq_flag_o = cmd_flag_r;
	assign prox3_irq_flag_o = p3_flag;
	assign unlocked_o = unlocked_r;
	assign osc_run_o = osc_r;
	assign wake_o = wake_r;
	assign als_meas_o = als_r;

	// Helper: cycles between wakes under a steady code
	logic [31:0] gap_r;
	logic steady_r;
	logic [7:0] last_code_r;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			gap_r <= 32'h0;
			steady_r <= 1'b0;
			last_code_r <= 8'h00;
		end else begin
			last_code_r <= wake_code_r;
			gap_r <= wake_r ? 32'h0 : gap_r + 32'h1;
			if (last_code_r != wake_code_r) begin
				steady_r <= 1'b0;
			end else if (wake_r) begin
				steady_r <= 1'b1;
			end
		end
	end

	a_cmd_any_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
		reply_wr_i && cmd_mode == 2'b00 |=> cmd_irq_flag_o)
		else $error("command flag missed a reply write");
	a_cmd_err_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_mode == 2'b01 && cmd_flag_clr_i &&
		!(reply_wr_i && reply_data_i[7]) |=> !cmd_irq_flag_o)
		else $error("command flag set by a non-error reply");
	a_int_gated: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!int_out_enable_i || (!cmd_irq_enable_i && !prox3_irq_enable_i)
		|=> !int_oe_o)
		else $error("interrupt line driven while not enabled");
	a_int_drives: assert property (@(posedge clk_i) disable iff (!rstn_i)
		int_out_enable_i && ((cmd_irq_flag_o && cmd_irq_enable_i) ||
		(prox3_irq_flag_o && prox3_irq_enable_i)) |=> int_oe_o)
		else $error("interrupt line not driven for an enabled flag");
	a_osc_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wake_code_r == 8'h00 |=> !osc_run_o && !wake_o)
		else $error("wake activity with wake code zero");
	a_wake_gap: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wake_o && steady_r && last_code_r == wake_code_r |->
		gap_r == 32'(wake_period) * 32'(TICK_CYCLES) - 32'h1)
		else $error("wake interval differs from decoded period");
	a_wake_table: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(wake_code_r == 8'h84 -> wake_period == 16'h0140) &&
		(wake_code_r == 8'h94 -> wake_period == 16'h0280) &&
		(wake_code_r == 8'hb9 -> wake_period == 16'h0c80) &&
		(wake_code_r == 8'hdf -> wake_period == 16'h3e00) &&
		(wake_code_r == 8'hff -> wake_period == 16'hf800))
		else $error("wake code expanded wrongly");
	a_als_table: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(als_code_r == 8'h08 -> als_mult == 16'h0001) &&
		(als_code_r == 8'h32 -> als_mult == 16'h000a) &&
		(als_code_r == 8'h69 -> als_mult == 16'h0064))
		else $error("ambient code expanded wrongly");
	a_als_on_wake: assert property (@(posedge clk_i) disable iff (!rstn_i)
		als_meas_o |-> wake_o && $past(als_code_r) != 8'h00)
		else $error("ambient measurement off a wake or while disabled");

endmodule : sensor_wake_scheduler

// >>> tb/i2c_host_model.sv
/*
 * Behavioural I2C host that reaches the scheduler registers.
 * Assumes a pulled-up open-drain SDA and the 10 ns core clock; SCL has
 * an 80 ns period and rests high between frames.
 */
`timescale 1ns/1ps

module i2c_host_model (
	input wire logic clk_i,
	input wire logic dev_pull_i,
	output logic scl_o,
	output logic sda_o
);
	logic host_pull = 1'b0;
	initial scl_o = 1'b1;
	// Released wire floats to the pull-up level
	assign sda_o = ~(host_pull | dev_pull_i);

	task half;
		repeat (4) @(posedge clk_i);
		#1;
	endtask : half

	task bit_io(input logic b, output logic r);
		host_pull = ~b;
		half();
		scl_o = 1'b1;
		half();
		r = sda_o;
		scl_o = 1'b0;
	endtask : bit_io

	task start_c;
		host_pull = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		host_pull = 1'b1;
		half();
		scl_o = 1'b0;
	endtask : start_c

	task stop_c;
		host_pull = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		host_pull = 1'b0;
		half();
	endtask : stop_c

	task xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
		output logic ack);
		logic t;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], t);
			r[i] = t;
		end
		bit_io(a, ack);
	endtask : xfer

	task wr(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2;
		a1 = 1'b0;
		a2 = 1'b0;
		// Wake codes one to twenty-three are never put on the bus
		if (ptr == 8'h08 && d > 8'h00 && d < 8'h18) d = 8'h18;
		start_c();
		xfer({dev, 1'b0}, 1'b1, r, a0);
		if (a0 === 1'b0) begin
			xfer(ptr, 1'b1, r, a1);
			xfer(d, 1'b1, r, a2);
		end
		stop_c();
		ok = (a0 | a1 | a2) === 1'b0;
	endtask : wr

	task rd(input logic [6:0] dev, input logic [7:0] ptr,
		output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2, n;
		start_c();
		xfer({dev, 1'b0}, 1'b1, r, a0);
		xfer(ptr, 1'b1, r, a1);
		start_c();
		xfer({dev, 1'b1}, 1'b1, r, a2);
		// Single-byte read ends with a not-acknowledge
		xfer(8'hff, 1'b1, d, n);
		stop_c();
		ok = (a0 | a1 | a2) === 1'b0;
	endtask : rd
endmodule : i2c_host_model

// >>> tb/test_sensor_wake_scheduler.sv
/*
 * Self-checking bench for the wake scheduler and interrupt modes.
 * Assumes the I2C host model and a shortened tick of two cycles.
 */
`timescale 1ns/1ps
`include "sched_cfg.svh"

module test_sensor_wake_scheduler;
	import sched_pkg::*;
	localparam int TICK = 2;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic scl, sda, sda_o, sda_oe, int_o, int_oe, cmd_flag, p3_flag;
	logic unlocked, osc_run, wake, ambient_light;
	logic reply_wr = 1'b0;
	logic [7:0] reply_data = 8'h00;
	logic cmd_en = 1'b0, p3_en = 1'b0, oe_en = 1'b0;
	logic cmd_clr = 1'b0, p3_clr = 1'b0;
	prox_meas_type meas = '0;
	logic [15:0] thr = 16'h0000;
	int failures = 0;
	int n_checks = 0;

	always #5 clk = ~clk;

	sensor_wake_scheduler #(.TICK_CYCLES(TICK)) uut (.clk_i(clk),
		.rstn_i(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(sda_oe), .reply_wr_i(reply_wr), .reply_data_i(reply_data),
		.cmd_irq_enable_i(cmd_en), .prox3_irq_enable_i(p3_en),
		.int_out_enable_i(oe_en), .cmd_flag_clr_i(cmd_clr),
		.prox3_flag_clr_i(p3_clr), .prox3_meas_i(meas),
		.prox3_threshold_i(thr), .int_o(int_o), .int_oe_o(int_oe),
		.cmd_irq_flag_o(cmd_flag), .prox3_irq_flag_o(p3_flag),
		.unlocked_o(unlocked), .osc_run_o(osc_run), .wake_o(wake),
		.als_meas_o(ambient_light));

	i2c_host_model host (.clk_i(clk), .dev_pull_i(sda_oe), .scl_o(scl),
		.sda_o(sda));

	task check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s seen %0h expected %0h",
				$time, what, seen, exp);
		end
	endtask : check

	task results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results

	task step;
		@(posedge clk);
		#1;
	endtask : step

	function automatic logic [15:0] expand(input logic [7:0] c,
		input bit als_tab);
		logic [31:0] v;
		v = ((32'd16 + c[3:0]) << c[7:4]) >> 4;
		if (c == 8'h00) v = 32'd0;
		if (als_tab && c == 8'h32) v = 32'd10;
		return v[15:0];
	endfunction : expand

	task wreg(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		host.wr(`I2C_DEV_ADDR, a, d, ok);
		check(ok, 1, "write ack");
	endtask : wreg

	task rreg(input logic [7:0] a, input logic [7:0] e);
		logic ok;
		logic [7:0] d;
		host.rd(`I2C_DEV_ADDR, a, d, ok);
		check(ok, 1, "read ack");
		check(d, e, "read data");
	endtask : rreg

	// Cycles and wakes up to the next wake or ambient pulse
	task wait_for(input bit use_als, output int cyc, output int wakes);
		cyc = 0;
		wakes = 0;
		do begin
			step();
			cyc++;
			if (wake === 1'b1) wakes++;
			if (cyc > 20000) begin
				failures++;
				$display("CHECK FAILED at %0t: wait bound used up", $time);
				results();
			end
		end while ((use_als ? ambient_light : wake) !== 1'b1);
	endtask : wait_for

	initial begin
		int c, w;
		logic [7:0] v, k;
		logic [1:0] m;
		logic ab, pa, ef, ok;
		logic [15:0] val;
		void'($urandom(43));
		repeat (16) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (4) step();
		check({cmd_flag, p3_flag, int_oe, wake, ambient_light, osc_run}, 0, "reset");
		check({int_o, sda_o}, 0, "pin values");
		for (int a = 6; a <= 9; a++) rreg(8'(a), 8'h00);
		wreg(8'h07, `UNLOCK_VALUE);
		step();
		check(unlocked, 1, "key");
		v = 8'($urandom);
		wreg(8'h09, v);
		rreg(8'h09, v);
		wreg(8'h06, v);
		rreg(8'h06, {4'h0, v[3:0]});
		wreg(8'h0a, v);
		rreg(8'h0a, 8'h00);
		host.wr(`I2C_DEV_ADDR ^ 7'h01, 8'h09, 8'h00, ok);
		check(ok, 0, "foreign address");
		wreg(8'h09, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 16; i++) begin
			m = 2'(i >> 2);
			cmd_en = i[0];
			oe_en = 1'($urandom);
			p3_en = 1'($urandom);
			wreg(8'h06, {4'h0, m, 2'b10});
			cmd_clr = 1'b1;
			p3_clr = 1'b1;
			step();
			{cmd_clr, p3_clr} = 2'b00;
			reply_wr = 1'b1;
			reply_data = {i[1], 7'($urandom)};
			step();
			reply_wr = 1'b0;
			ef = (m == `CMD_MODE_ANY) || (m == `CMD_MODE_ERR && i[1]);
			check(cmd_flag, ef, "command flag");
			step();
			check(int_oe, ef & cmd_en & oe_en, "cmd pin");
			check(cmd_flag, ef, "command flag held");
		end
		$display("test command interrupt done");
		{p3_en, oe_en, cmd_en} = 3'b110;
		pa = 1'b0;
		for (int i = 0; i < 20; i++) begin
			m = 2'(i / 5);
			if (i % 5 == 0) begin
				wreg(8'h06, {6'h00, m});
				thr = 16'h0100 + 16'($urandom % 32'hfe00);
			end
			ab = 1'((5'h0d >> (i % 5)) & 1);
			if (ab) val = thr + 16'd1 + 16'($urandom % 256);
			else if (i % 5 == 4) val = thr;
			else val = thr - 16'd1 - 16'($urandom % 255);
			p3_clr = 1'b1;
			step();
			p3_clr = 1'b0;
			meas = '{1'b1, val};
			step();
			meas.done = 1'b0;
			ef = (m == 2'b00) | (m == 2'b01 && ab != pa) | (m == 2'b11 && ab);
			pa = ab;
			check(p3_flag, ef, "third flag");
			step();
			check(int_oe, ef, "third pin");
		end
		$display("test third channel done");
		// Long codes are only decoded here; their wake spacing is too slow
		wreg(8'h08, 8'hdf);
		check(uut.wake_period, 16'h3e00, "code 0xdf");
		wreg(8'h08, 8'hff);
		check(uut.wake_period, 16'hf800, "code 0xff");
		for (int i = 0; i < 6; i++) begin
			k = i == 0 ? 8'h84 : i == 1 ? 8'h94 : 8'hb9;
			if (i > 2) k = 8'h18 + 8'($urandom % 56);
			wreg(8'h08, k);
			check(osc_run, 1, "oscillator on");
			wait_for(0, c, w);
			wait_for(0, c, w);
			check(c, expand(k, 0) * TICK, "wake");
		end
		$display("test wake interval done");
		// Short wake period keeps the run brief; a host would pick long ones
		wreg(8'h08, 8'h18);
		for (int i = 0; i < 3; i++) begin
			k = i == 0 ? 8'h08 : i == 1 ? 8'h32 : 8'h69;
			wreg(8'h09, k);
			wait_for(1, c, w);
			wait_for(1, c, w);
			check(w, expand(k, 1), "ambient spacing");
			check(wake, 1, "ambient on a wake");
		end
		wreg(8'h09, 8'h00);
		c = 0;
		w = 0;
		repeat (60) begin
			step();
			c += int'(ambient_light);
			w += int'(wake);
		end
		check(c, 0, "ambient off");
		check(w, 60 / (3 * TICK), "wakes go on");
		wreg(8'h08, 8'h00);
		check(osc_run, 0, "oscillator off");
		w = 0;
		repeat (200) begin
			step();
			w += int'(wake);
		end
		check(w, 0, "no wakes");
		$display("test scheduler done");
		results();
	end
endmodule : test_sensor_wake_scheduler
